//--- pkg/smtlb_pkg.sv
package smtlb_pkg;

  // Word byte addresses on the register bus.
  localparam logic [11:0] ADDR_SECCFG = 12'h000;
  localparam logic [11:0] ADDR_IDENT0 = 12'h004;
  localparam logic [11:0] ADDR_IDENT1 = 12'h008;
  localparam logic [11:0] ADDR_CONFIG0 = 12'h00C;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam logic [11:0] ADDR_LOOKUP = 12'h014;
  localparam logic [11:0] ADDR_SEC_ALL = 12'h020;
  localparam logic [11:0] ADDR_MON_ALL = 12'h024;
  localparam logic [11:0] ADDR_HYP_ALL = 12'h028;
  localparam logic [11:0] ADDR_NSG_ALL = 12'h02C;
  localparam logic [11:0] ADDR_VAL_LO = 12'h030;
  localparam logic [11:0] ADDR_VAL_HI = 12'h034;
  localparam logic [11:0] ADDR_VA_LO = 12'h038;
  localparam logic [11:0] ADDR_VA_HI = 12'h03C;
  localparam logic [11:0] ADDR_MATCH_BASE = 12'h400;
  localparam logic [11:0] ADDR_S2C_BASE = 12'h800;
  localparam logic [11:0] ADDR_TABLE_MASK = 12'hC00;

  // Field positions in the stored words.
  localparam int GROUP_LSB = 8;
  localparam int BANK_LSB = 0;
  localparam int CNT_W = 8;
  localparam int VALID_BIT = 31;
  localparam int MASK_LSB = 16;
  localparam int STD_W = 15;
  localparam int EXT_W = 16;
  localparam int EXT_VALID_BIT = 10;
  localparam int EXT_EN_BIT = 0;
  localparam int ADDR_W = 44;
  localparam int ADDR_TOP = 43;
  localparam int GRANULE_LO = 0;
  localparam int GRANULE_HI = 3;
  localparam int SCHEME32_LSB = 20;

  // Invalidation command kinds.
  typedef enum logic [2:0] {
    INV_NONE = 3'h0,
    INV_SECURE = 3'h1,
    INV_MONITOR = 3'h2,
    INV_HYP = 3'h3,
    INV_GUEST = 3'h4,
    INV_VA_LAST = 3'h5,
    INV_VA = 3'h6
  } inv_kind_t;

  // One invalidation request as presented to the TLB.
  typedef struct packed {
    logic valid;
    inv_kind_t kind;
    logic [63:0] address;
  } inv_req_t;

endpackage : smtlb_pkg

//--- design/stream_match_tlb_invalidate.sv
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/10ps

// Behaviour
// - Non-secure ident group count uses override
// - Group override resets to implemented groups
// - Non-secure bank count uses bank override
// - Bank override resets to implemented banks
// - Unneeded override upper bits read zero
// - Bank override change may retry stalls
// - Standard entry searched only when valid
// - Mask bit one ignores identifier bit
// - Identifier low, bit fifteen reserved
// - Extended enable selects sixteen-bit layout
// - Extended entry valid via mapping flag
// - All entries share identifier widths
// - Entries writable only in matching mode
// - Secure invalidate-all clears secure entries
// - Without two states secure command reserved
// - Monitor invalidate-all clears monitor entries
// - Hypervisor invalidate-all clears hyp entries
// - Guest invalidate-all clears guest entries
// - Address field extended, granule and scheme
// - Last-level command invalidates last level
// - Extended valid flag ignored when disabled
module stream_match_tlb_invalidate #(
  parameter int NUM_GROUPS = 16,
  parameter int NUM_BANKS = 8,
  parameter int NUM_S2_BANKS = 2,
  parameter int GROUP_BITS = 5,
  parameter int BANK_BITS = 4,
  parameter bit TWO_STATES = 1'b1,
  parameter bit MATCHING = 1'b1
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Security state of the current register access.
  input wire logic secureAccess,
  // Stream lookup port.
  input wire logic lookupReq,
  input wire logic [15:0] lookupStream,
  output logic lookupHit,
  output logic [7:0] lookupGroup,
  output logic lookupMulti,
  // Invalidation request to the TLB and stall retry.
  output smtlb_pkg::inv_req_t invReq,
  output logic retryStalls
);

  localparam logic [7:0] GROUPS_RESET = 8'(NUM_GROUPS);
  localparam logic [7:0] BANKS_RESET = 8'(NUM_BANKS);
  localparam logic [7:0] GROUP_KEEP = 8'((1 << GROUP_BITS) - 1);
  localparam logic [7:0] BANK_KEEP = 8'((1 << BANK_BITS) - 1);
  localparam int GIDX_W = $clog2(NUM_GROUPS);

  logic [7:0] groupOverride;
  logic [7:0] bankOverride;
  logic extEnable;
  logic [31:0] matchTable [NUM_GROUPS];
  logic extValid [NUM_GROUPS];
  logic [31:0] vaLastLow;
  logic [31:0] vaLow;
  logic [3:0] lastKind;
  logic [31:0] next_rdata;
  logic [31:0] wmask;
  logic access;
  logic writeHit;
  logic [GIDX_W-1:0] tableIdx;
  logic tableHit;
  logic s2cHit;
  logic [NUM_GROUPS-1:0] hitVec;

  // Byte-lane write merge, used by the match table entries and the two address low words.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  // Standard layout keeps bit fifteen reserved, so it is dropped on write and hidden on read.
  function automatic logic [31:0] std_clean(input logic [31:0] e, input logic xen);
    std_clean = e;
    if (!xen) begin
      std_clean[smtlb_pkg::MASK_LSB-1] = 1'b0;
    end
  endfunction : std_clean

  // Standard or extended comparison of one entry against a stream.
  function automatic logic entry_match(input logic [31:0] e, input logic xv, input logic xen,
                                       input logic [15:0] sid);
    logic [15:0] idv;
    logic [15:0] mk;
    idv = 16'h0000;
    mk = 16'h0000;
    if (xen) begin
      idv = e[smtlb_pkg::EXT_W-1:0];
      mk = e[smtlb_pkg::MASK_LSB +: smtlb_pkg::EXT_W];
      entry_match = xv && (((idv ^ sid) & ~mk) == 16'h0000);
    end else begin
      idv = {1'b0, e[smtlb_pkg::STD_W-1:0]};
      mk = {1'b1, e[smtlb_pkg::MASK_LSB +: smtlb_pkg::STD_W]};
      entry_match = e[smtlb_pkg::VALID_BIT] && (((idv ^ sid) & ~mk) == 16'h0000);
    end
  endfunction : entry_match

  assign access = cyc_i && stb_i && !ack_o;
  assign writeHit = access && we_i;
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign tableIdx = adr_i[GIDX_W+1:2];
  assign tableHit = ((adr_i & smtlb_pkg::ADDR_TABLE_MASK) == smtlb_pkg::ADDR_MATCH_BASE)
                    && (32'(adr_i[9:2]) < NUM_GROUPS);
  assign s2cHit = ((adr_i & smtlb_pkg::ADDR_TABLE_MASK) == smtlb_pkg::ADDR_S2C_BASE)
                  && (32'(adr_i[9:2]) < NUM_GROUPS);

  // Single-cycle acknowledge; dropped in the cycle after it is given.
  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= access;
    end
  end

  // Override fields; only Secure software may change them.
  always_ff @(posedge mclk) begin
    if (rst) begin
      groupOverride <= GROUPS_RESET;
      bankOverride <= BANKS_RESET;
    end else if (writeHit && secureAccess && adr_i == smtlb_pkg::ADDR_SECCFG) begin
      if (sel_i[1]) begin
        groupOverride <= dat_i[smtlb_pkg::GROUP_LSB +: smtlb_pkg::CNT_W] & GROUP_KEEP;
      end
      if (sel_i[0]) begin
        bankOverride <= dat_i[smtlb_pkg::BANK_LSB +: smtlb_pkg::CNT_W] & BANK_KEEP;
      end
    end
  end

  // A change of bank allocation lets stalled banks retry once.
  always_ff @(posedge mclk) begin
    if (rst) begin
      retryStalls <= 1'b0;
    end else begin
      retryStalls <= writeHit && secureAccess && adr_i == smtlb_pkg::ADDR_SECCFG && sel_i[0]
                     && ((dat_i[smtlb_pkg::BANK_LSB +: smtlb_pkg::CNT_W] & BANK_KEEP) != bankOverride);
    end
  end

  // Extended identifier enable.
  always_ff @(posedge mclk) begin
    if (rst) begin
      extEnable <= 1'b0;
    end else if (writeHit && adr_i == smtlb_pkg::ADDR_CONFIG0 && sel_i[0]) begin
      extEnable <= dat_i[smtlb_pkg::EXT_EN_BIT];
    end
  end

  // Match table: one width for every entry, reserved bit held at zero.
  // Contents are cleared on reset only to keep simulation free of unknowns.
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        matchTable[g] <= 32'h00000000;
        extValid[g] <= 1'b0;
      end
    end else if (writeHit && MATCHING) begin
      if (tableHit) begin
        matchTable[tableIdx] <= std_clean(merge(matchTable[tableIdx], dat_i, wmask), extEnable);
      end
      if (s2cHit && sel_i[1]) begin
        extValid[tableIdx] <= dat_i[smtlb_pkg::EXT_VALID_BIT];
      end
    end
  end

  // Stored low halves of the by-address commands.
  always_ff @(posedge mclk) begin
    if (rst) begin
      vaLastLow <= 32'h00000000;
      vaLow <= 32'h00000000;
    end else if (writeHit) begin
      if (adr_i == smtlb_pkg::ADDR_VAL_LO) begin
        vaLastLow <= merge(vaLastLow, dat_i, wmask);
      end
      if (adr_i == smtlb_pkg::ADDR_VA_LO) begin
        vaLow <= merge(vaLow, dat_i, wmask);
      end
    end
  end

  // Command issue: whole-TLB writes fire regardless of data, by-address
  // writes fire on the upper word and carry the sign-extended address, with bits 63:32 cleared when bit 31 is set.
  always_ff @(posedge mclk) begin
    logic [63:0] a;
    a = 64'h0;
    if (rst) begin
      invReq <= '0;
    end else begin
      invReq.valid <= 1'b0;
      if (writeHit) begin
        case (adr_i)
          smtlb_pkg::ADDR_SEC_ALL: begin
            invReq.valid <= TWO_STATES;
            invReq.kind <= smtlb_pkg::INV_SECURE;
            invReq.address <= 64'h0;
          end
          smtlb_pkg::ADDR_MON_ALL: begin
            invReq.valid <= TWO_STATES;
            invReq.kind <= smtlb_pkg::INV_MONITOR;
            invReq.address <= 64'h0;
          end
          smtlb_pkg::ADDR_HYP_ALL: begin
            invReq.valid <= 1'b1;
            invReq.kind <= smtlb_pkg::INV_HYP;
            invReq.address <= 64'h0;
          end
          smtlb_pkg::ADDR_NSG_ALL: begin
            invReq.valid <= 1'b1;
            invReq.kind <= smtlb_pkg::INV_GUEST;
            invReq.address <= 64'h0;
          end
          smtlb_pkg::ADDR_VAL_HI, smtlb_pkg::ADDR_VA_HI: begin
            a[smtlb_pkg::ADDR_W-1:0] = {dat_i[11:0],
              (adr_i == smtlb_pkg::ADDR_VAL_HI) ? vaLastLow : vaLow};
            a = {{20{a[smtlb_pkg::ADDR_TOP]}}, a[smtlb_pkg::ADDR_W-1:0]} << 12;
            if (dat_i[30]) begin
              a[15:12] = 4'h0;
            end
            if (dat_i[31]) begin
              a[63:32] = 32'h00000000;
            end
            invReq.valid <= TWO_STATES;
            invReq.kind <= (adr_i == smtlb_pkg::ADDR_VAL_HI) ? smtlb_pkg::INV_VA_LAST
                                                            : smtlb_pkg::INV_VA;
            invReq.address <= a;
          end
          default: begin
            invReq.valid <= 1'b0;
          end
        endcase
      end
    end
  end

  // Read mux; Non-secure readers see the reduced counts.
  always_comb begin
    next_rdata = 32'h00000000;
    case (adr_i)
      smtlb_pkg::ADDR_SECCFG: next_rdata = secureAccess ? {16'h0000, groupOverride, bankOverride} : 32'h0;
      smtlb_pkg::ADDR_IDENT0: next_rdata = {24'h000000, secureAccess ? GROUPS_RESET : groupOverride};
      smtlb_pkg::ADDR_IDENT1: next_rdata = {8'(NUM_S2_BANKS), 16'h0000,
                                            secureAccess ? BANKS_RESET : bankOverride};
      smtlb_pkg::ADDR_CONFIG0: next_rdata = {31'h00000000, extEnable};
      smtlb_pkg::ADDR_STATUS: next_rdata = {lastKind, 28'h0000000};
      smtlb_pkg::ADDR_LOOKUP: next_rdata = {22'h000000, lookupMulti, lookupHit, lookupGroup};
      default: begin
        if (tableHit && MATCHING) begin
          next_rdata = std_clean(matchTable[tableIdx], extEnable);
        end else if (s2cHit) begin
          next_rdata = 32'(extValid[tableIdx]) << smtlb_pkg::EXT_VALID_BIT;
        end
      end
    endcase
  end

  // Registered read data.
  always_ff @(posedge mclk) begin
    if (rst) begin
      dat_o <= 32'h00000000;
    end else if (access && !we_i) begin
      dat_o <= next_rdata;
    end
  end

  // Last issued command kind, for software to observe.
  always_ff @(posedge mclk) begin
    if (rst) begin
      lastKind <= 4'h0;
    end else if (invReq.valid) begin
      lastKind <= {1'b0, invReq.kind};
    end
  end

  // Parallel comparators, one per entry.
  generate
    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_cmp
      assign hitVec[g] = MATCHING && entry_match(matchTable[g], extValid[g], extEnable, lookupStream);
    end
  endgenerate

  // Lookup result, lowest hit wins; multiple hits are flagged.
  always_ff @(posedge mclk) begin
    logic found;
    logic [7:0] idx;
    found = 1'b0;
    idx = 8'h00;
    for (int g = NUM_GROUPS - 1; g >= 0; g--) begin
      if (hitVec[g]) begin
        found = 1'b1;
        idx = 8'(g);
      end
    end
    if (rst) begin
      lookupHit <= 1'b0;
      lookupGroup <= 8'h00;
      lookupMulti <= 1'b0;
    end else if (lookupReq) begin
      lookupHit <= found;
      lookupGroup <= idx;
      lookupMulti <= (hitVec & (hitVec - 1'b1)) != '0;
    end
  end

  // Non-secure identification read returns the override.
  chk_ident_override: assert property (@(posedge mclk) disable iff (rst)
    access && !we_i && !secureAccess && adr_i == smtlb_pkg::ADDR_IDENT0 |=> dat_o[7:0] == groupOverride)
    else $error("Non-secure group count not overridden");
  chk_group_reset: assert property (@(posedge mclk) $fell(rst) |-> groupOverride == GROUPS_RESET)
    else $error("Group override reset wrong");
  chk_bank_override: assert property (@(posedge mclk) disable iff (rst)
    access && !we_i && !secureAccess && adr_i == smtlb_pkg::ADDR_IDENT1 |=> dat_o[7:0] == bankOverride)
    else $error("Non-secure bank count not overridden");
  chk_bank_reset: assert property (@(posedge mclk) $fell(rst) |-> bankOverride == BANKS_RESET)
    else $error("Bank override reset wrong");
  chk_upper_zero: assert property (@(posedge mclk) disable iff (rst)
    ((bankOverride & ~BANK_KEEP) == 8'h00) && ((groupOverride & ~GROUP_KEEP) == 8'h00))
    else $error("Unimplemented override bits set");
  chk_invalid_nohit: assert property (@(posedge mclk) disable iff (rst)
    lookupReq && !extEnable && !matchTable[0][smtlb_pkg::VALID_BIT] |=> !(lookupHit && lookupGroup == 8'h00))
    else $error("Invalid entry matched");
  chk_ext_valid: assert property (@(posedge mclk) disable iff (rst)
    lookupReq && extEnable && !extValid[0] |=> !(lookupHit && lookupGroup == 8'h00))
    else $error("Extended entry matched without valid");
  chk_any_write: assert property (@(posedge mclk) disable iff (rst)
    writeHit && adr_i == smtlb_pkg::ADDR_HYP_ALL |=> invReq.valid && invReq.kind == smtlb_pkg::INV_HYP)
    else $error("Hypervisor invalidate not issued");
  chk_guest_write: assert property (@(posedge mclk) disable iff (rst)
    writeHit && adr_i == smtlb_pkg::ADDR_NSG_ALL |=> invReq.valid ##1 !invReq.valid)
    else $error("Guest invalidate not a single pulse");
  chk_secure_reserved: assert property (@(posedge mclk) disable iff (rst)
    writeHit && adr_i == smtlb_pkg::ADDR_SEC_ALL |=> invReq.valid == TWO_STATES)
    else $error("Secure invalidate handling wrong");
  chk_address_extend: assert property (@(posedge mclk) disable iff (rst)
    invReq.valid && invReq.kind == smtlb_pkg::INV_VA |-> invReq.address[63:56] == {8{invReq.address[55]}})
    else $error("Address not sign extended");

  // Standard-format reads never expose the reserved bit.
  chk_reserved_read: assert property (@(posedge mclk) disable iff (rst)
    access && !we_i && tableHit && !extEnable |=> !dat_o[smtlb_pkg::MASK_LSB-1])
    else $error("Reserved match bit read back set");
  chk_retry_change: assert property (@(posedge mclk) disable iff (rst)
    retryStalls |-> $changed(bankOverride))
    else $error("Retry pulse without bank override change");
  chk_monitor_all: assert property (@(posedge mclk) disable iff (rst)
    writeHit && adr_i == smtlb_pkg::ADDR_MON_ALL
    |=> invReq.valid == TWO_STATES && invReq.kind == smtlb_pkg::INV_MONITOR)
    else $error("Monitor invalidate not issued");
  chk_va_last_kind: assert property (@(posedge mclk) disable iff (rst)
    writeHit && adr_i == smtlb_pkg::ADDR_VAL_HI
    |=> invReq.valid == TWO_STATES && invReq.kind == smtlb_pkg::INV_VA_LAST)
    else $error("Last-level invalidate not issued");
  chk_ack_single: assert property (@(posedge mclk) disable iff (rst)
    ack_o |=> !ack_o)
    else $error("Acknowledge longer than one cycle");

endmodule : stream_match_tlb_invalidate

//--- bench/tb.sv
`timescale 1ns/10ps

module tb;
  // Bench stimulus and observed outputs.
  logic mclk, rst, cyc, stb, we, secAcc, lkReq;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, rd;
  logic [15:0] lkStream;
  logic ack, lkHit, lkMulti, retry;
  logic [7:0] lkGroup;
  smtlb_pkg::inv_req_t inv, invAck;
  int n_mismatch = 0;
  int comparisons = 0;
  int retryCount = 0;
  int invCount = 0;

  stream_match_tlb_invalidate stream_match_tlb_invalidate_i (.mclk(mclk), .rst(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .secureAccess(secAcc),
    .lookupReq(lkReq), .lookupStream(lkStream), .lookupHit(lkHit), .lookupGroup(lkGroup),
    .lookupMulti(lkMulti), .invReq(inv), .retryStalls(retry));

  // Clock at 100 MHz.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Pulse counters catch a pulse that lasts longer than one cycle or fires twice.
  always @(posedge mclk) begin
    if (retry === 1'b1) retryCount++;
    if (inv.valid === 1'b1) invCount++;
  end

  task automatic end_sim();
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t word got %h expected %h", $time, got, exp);
    end
  endtask : chkWord

  task automatic chkAddr(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t address got %h expected %h", $time, got, exp);
    end
  endtask : chkAddr

  // One classic cycle; the request stands until ack is sampled high, and only the watchdog ends a wait.
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic s);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    secAcc <= s;
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    rd = rdat;
    invAck = inv;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  // The result registers update at the edge that samples the request.
  task automatic lookup(input logic [15:0] sid, input logic hit, input logic [7:0] grp);
    @(posedge mclk);
    lkReq <= 1'b1;
    lkStream <= sid;
    @(posedge mclk);
    lkReq <= 1'b0;
    #1;
    chkWord({31'h0, lkHit}, {31'h0, hit});
    if (hit) chkWord({24'h0, lkGroup}, {24'h0, grp});
  endtask : lookup

  task automatic test_reset();
    wb(1'b0, smtlb_pkg::ADDR_SECCFG, 32'h0, 1'b1);
    chkWord(rd, 32'h0000_1008);
    wb(1'b0, smtlb_pkg::ADDR_IDENT0, 32'h0, 1'b0);
    chkWord({24'h0, rd[7:0]}, 32'h10);
  endtask : test_reset

  // Every bank override written stays at or above the two stage-two banks.
  task automatic test_override();
    wb(1'b1, smtlb_pkg::ADDR_SECCFG, 32'h0000_0503, 1'b1);
    wb(1'b0, smtlb_pkg::ADDR_IDENT0, 32'h0, 1'b0);
    chkWord({24'h0, rd[7:0]}, 32'h05);
    wb(1'b0, smtlb_pkg::ADDR_IDENT1, 32'h0, 1'b0);
    chkWord(rd, 32'h0200_0003);
    wb(1'b0, smtlb_pkg::ADDR_IDENT0, 32'h0, 1'b1);
    chkWord({24'h0, rd[7:0]}, 32'h10);
    wb(1'b1, smtlb_pkg::ADDR_SECCFG, 32'h0000_FFFF, 1'b1);
    wb(1'b0, smtlb_pkg::ADDR_SECCFG, 32'h0, 1'b1);
    chkWord(rd, 32'h0000_1F0F);
    wb(1'b1, smtlb_pkg::ADDR_SECCFG, 32'h0000_1F0F, 1'b1);
    chkWord(retryCount, 32'd2);
    wb(1'b1, smtlb_pkg::ADDR_SECCFG, 32'h0, 1'b0);
    wb(1'b0, smtlb_pkg::ADDR_SECCFG, 32'h0, 1'b0);
    chkWord(rd, 32'h0);
    wb(1'b0, smtlb_pkg::ADDR_SECCFG, 32'h0, 1'b1);
    chkWord(rd, 32'h0000_1F0F);
  endtask : test_override

  // Entries are rewritten only while no lookup is in flight.
  task automatic test_match();
    wb(1'b1, 12'h400, 32'h8001_0122, 1'b1);
    wb(1'b1, 12'h404, 32'h0000_0200, 1'b1);
    wb(1'b1, 12'h40C, 32'h8000_8300, 1'b1);
    wb(1'b0, 12'h40C, 32'h0, 1'b1);
    chkWord(rd, 32'h8000_0300);
    wb(1'b0, 12'h400, 32'h0, 1'b1);
    chkWord(rd, 32'h8001_0122);
    lookup(16'h0123, 1'b1, 8'h00);
    lookup(16'h0122, 1'b1, 8'h00);
    lookup(16'h0121, 1'b0, 8'h00);
    lookup(16'h0200, 1'b0, 8'h00);
    lookup(16'h0300, 1'b1, 8'h03);
    chkWord({31'h0, lkMulti}, 32'h0);
    wb(1'b1, 12'h414, 32'h8000_0300, 1'b1);
    lookup(16'h0300, 1'b1, 8'h03);
    chkWord({31'h0, lkMulti}, 32'h1);
    wb(1'b0, smtlb_pkg::ADDR_LOOKUP, 32'h0, 1'b1);
    chkWord(rd, 32'h0000_0303);
    wb(1'b1, smtlb_pkg::ADDR_CONFIG0, 32'h0000_0001, 1'b1);
    wb(1'b1, 12'h408, 32'h0000_8200, 1'b1);
    wb(1'b1, 12'h410, 32'h00FF_9000, 1'b1);
    lookup(16'h8200, 1'b0, 8'h00);
    wb(1'b1, 12'h808, 32'h0000_0400, 1'b1);
    wb(1'b1, 12'h810, 32'h0000_0400, 1'b1);
    lookup(16'h8200, 1'b1, 8'h02);
    lookup(16'h90AB, 1'b1, 8'h04);
    lookup(16'h91AB, 1'b0, 8'h00);
    lookup(16'h0123, 1'b0, 8'h00);
    wb(1'b1, smtlb_pkg::ADDR_CONFIG0, 32'h0, 1'b1);
    lookup(16'h0200, 1'b0, 8'h00);
    lookup(16'h0123, 1'b1, 8'h00);
    wb(1'b1, 12'h400, 32'h0001_0122, 1'b1);
    lookup(16'h0123, 1'b0, 8'h00);
  endtask : test_match

  task automatic test_inval();
    logic [11:0] adrs [4];
    adrs = '{smtlb_pkg::ADDR_SEC_ALL, smtlb_pkg::ADDR_MON_ALL, smtlb_pkg::ADDR_HYP_ALL, smtlb_pkg::ADDR_NSG_ALL};
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, adrs[i], (i % 2 == 0) ? 32'hFFFF_FFFF : 32'h0, 1'b1);
      chkWord({28'h0, invAck.valid, invAck.kind}, 32'h8 + i + 1);
    end
    // One more edge lets the pulse counter see the last pulse.
    @(posedge mclk);
    chkWord(invCount, 32'd4);
  endtask : test_inval

  // Address words: low word first, upper word fires the command.
  task automatic va(input logic [11:0] lo, input logic [31:0] l, input logic [31:0] h, input logic [63:0] exp,
                    input logic [2:0] kind);
    wb(1'b1, lo, l, 1'b1);
    wb(1'b1, lo + 12'h004, h, 1'b1);
    chkWord({28'h0, invAck.valid, invAck.kind}, {28'h0, 1'b1, kind});
    chkAddr(invAck.address, exp);
  endtask : va

  task automatic test_va();
    va(smtlb_pkg::ADDR_VA_LO, 32'h1234_5678, 32'h0000_0800, 64'hFF80_0123_4567_8000, 3'h6);
    va(smtlb_pkg::ADDR_VAL_LO, 32'h1234_5678, 32'h4000_0001, 64'h0000_1123_4567_0000, 3'h5);
    va(smtlb_pkg::ADDR_VA_LO, 32'h1234_5678, 32'h8000_0800, 64'h0000_0000_4567_8000, 3'h6);
    wb(1'b0, smtlb_pkg::ADDR_STATUS, 32'h0, 1'b1);
    chkWord(rd, 32'h6000_0000);
    chkWord(invCount, 32'd7);
  endtask : test_va

  // An unmapped place reads zero and a write there is dropped.
  task automatic test_unmapped();
    wb(1'b1, 12'h100, 32'hA5A5_A5A5, 1'b1);
    wb(1'b0, 12'h100, 32'h0, 1'b1); chkWord(rd, 32'h0);
    chkWord(invCount, 32'd7);
  endtask : test_unmapped

  // Main sequence with reset held for eight cycles.
  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 12'h0;
    sel = 4'h0;
    wdat = 32'h0;
    secAcc = 1'b0;
    lkReq = 1'b0;
    lkStream = 16'h0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    test_reset();
    test_override();
    test_match();
    test_inval();
    test_va();
    test_unmapped();
    end_sim();
  end

  // The whole sequence needs well under two thousand cycles.
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end
endmodule : tb
